// [hw/swpc_consts.svh]
// constants of the sleep, wake and reset controller
// assumes a 40 MHz system clock
`ifndef SWPC_CONSTS_SVH
`define SWPC_CONSTS_SVH
`define SWPC_CLK_MHZ 40
`define SWPC_SHALLOW_WAKE_NS 1000
`define SWPC_SHALLOW_WAKE_CYC ((`SWPC_SHALLOW_WAKE_NS*`SWPC_CLK_MHZ)/1000)
`define SWPC_DEEP_WAKE_NS 7000
// load plus two sync and two state steps keeps pin-to-ready under 7 us
`define SWPC_DEEP_WAKE_CYC ((`SWPC_DEEP_WAKE_NS*`SWPC_CLK_MHZ)/1000 - 5)
`define SWPC_RST_PULSE_CYC 16
`define SWPC_RTC_STABLE_MS 2000
`define SWPC_RTC_STABLE_CYC (`SWPC_RTC_STABLE_MS*`SWPC_CLK_MHZ*1000)
`define SWPC_RTC_DIV 1220
`define SWPC_ADDR_CTRL 12'h000
`define SWPC_ADDR_STAT 12'h004
`define SWPC_ADDR_WAKE 12'h008
`define SWPC_ADDR_INT 12'h00C
`define SWPC_CTRL_SLEEP_EN 0
`define SWPC_CTRL_DEEP_REQ 1
`define SWPC_CTRL_WAKEPIN_EN 2
`define SWPC_CTRL_RESET 32'h0000_0000
`define SWPC_NUM_GPIO 16
`endif

// [hw/swpc_pkg.sv]
// types of the sleep, wake and reset controller
// assumes nothing beyond the constants header
package swpc_pkg;
    typedef enum logic [2:0] {
        SWPC_ACTIVE = 3'b000,
        SWPC_SHALLOW = 3'b001,
        SWPC_DEEP = 3'b010,
        SWPC_WAKING = 3'b011
    } swpc_state_e;
    typedef logic [15:0] swpc_gpio_t;
endpackage : swpc_pkg

// [hw/swpc_sync_if.sv]
// interface carrying raw pins and their synchronised copies
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface swpc_sync_if;
    logic [19:0] raw;
    logic [19:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface : swpc_sync_if
`default_nettype wire

// [hw/swpc_sync.sv]
// two flip-flop synchroniser for the wake, radio, rtc and reset pins
// assumes pins are quiet levels, not pulses shorter than two cycles
`timescale 1ns/100ps
`default_nettype none
module swpc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synced out
    swpc_sync_if.dst sif
);
    logic [19:0] meta_reg;
    logic [19:0] sync_reg;
    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 20'h00000;
            sync_reg <= 20'h00000;
        end else begin
            meta_reg <= sif.raw;
            sync_reg <= meta_reg;
        end
    end
    assign sif.synced = sync_reg;
endmodule : swpc_sync
`default_nettype wire

// [hw/swpc_top.sv]
// sleep, wake and reset control of a wireless module
// assumes pins are asynchronous and software reaches registers over APB
// Functional notes
// - shallow sleep halts only the core and resumes within 1 us.
// - deep sleep stops system clocks and the serial port.
// - leaving deep sleep waits under 7 us before data is accepted.
// - deep sleep ends on wake pin, gpio irq, radio or rtc irq.
// - while the wake pin is high no sleep state is entered.
// - a gpio wake lasts only until its handler completes.
// - only one gpio may be the wake pin; others keep interrupts.
// - there is no command that wakes the device from deep sleep.
// - ram contents are retained in every power state.
// - reset comes from the pin, power-up or the watchdog.
// - an internal reset briefly pulls the reset pin low.
// - boot select high at reset release selects recovery mode.
// - clocks follow a 32.768 kHz rtc that needs two seconds to settle.
// - a gpio irq channel is one pin number on only one of two ports.
`timescale 1ns/100ps
`default_nettype none
`include "swpc_consts.svh"
module swpc_top #(
    parameter int unsigned RTC_STABLE_CYC = `SWPC_RTC_STABLE_CYC,
    parameter int unsigned WDOG_CYC = 32'd40000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // wake sources
    input wire logic [15:0] gpio_port_a,
    input wire logic [15:0] gpio_port_b,
    input wire logic radio_active,
    input wire logic rtc_alarm,
    input wire logic handler_done,
    // reset pin, open drain
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic boot_select,
    // power controls
    output logic core_halt,
    output logic sys_clk_en,
    output logic uart_en,
    output logic uart_ready,
    output logic ram_retain,
    output logic recovery_mode,
    output logic rtc_stable,
    output logic rtc_tick,
    output logic cpu_rst_n
);
    import swpc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    swpc_sync_if sif ();
    logic [3:0] wake_sel_reg, wake_sel_next;
    logic [15:0] irq_en_reg, irq_en_next;
    logic [15:0] port_sel_reg, port_sel_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [15:0] irq_pend_reg, irq_pend_next;
    logic [15:0] gpio_prev_reg;
    swpc_gpio_t gpio_mux;
    logic wake_pin, radio_s, rtc_s, rpin_s, boot_s;
    // wake pin is one gpio of port a chosen by software
    assign sif.raw = {gpio_port_a[wake_sel_reg] & ctrl_reg[2], radio_active,
                      rtc_alarm, reset_pin_in, 16'h0000};
    swpc_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sif(sif)
    );
    assign wake_pin = sif.synced[19];
    assign radio_s = sif.synced[18];
    assign rtc_s = sif.synced[17];
    assign rpin_s = sif.synced[16];
    // gpio ports go through their own two-stage chain
    logic [15:0] ga_m, ga_s, gb_m, gb_s;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ga_m <= 16'h0000;
            ga_s <= 16'h0000;
            gb_m <= 16'h0000;
            gb_s <= 16'h0000;
        end else begin
            ga_m <= gpio_port_a;
            ga_s <= ga_m;
            gb_m <= gpio_port_b;
            gb_s <= gb_m;
        end
    end
    // per channel one port only, picked by port_sel
    assign gpio_mux = (ga_s & ~port_sel_reg) | (gb_s & port_sel_reg);
    ////////////////////////////////////////////////////////////////////////
    // reset sources
    logic [31:0] wdog_reg, wdog_next;
    logic [4:0] ipulse_reg, ipulse_next;
    logic por_done_reg;
    logic int_rst;
    logic wdog_kick;
    assign int_rst = (wdog_reg == WDOG_CYC - 32'd1) || !por_done_reg;
    always_comb begin
        wdog_next = (wdog_kick || int_rst) ? 32'h0000_0000 : wdog_reg + 32'd1;
        ipulse_next = int_rst ? 5'(`SWPC_RST_PULSE_CYC) :
                      (ipulse_reg != 5'h00 ? ipulse_reg - 5'h01 : 5'h00);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reg <= 32'h0000_0000;
            ipulse_reg <= 5'h00;
            por_done_reg <= 1'b0;
        end else begin
            wdog_reg <= wdog_next;
            ipulse_reg <= ipulse_next;
            por_done_reg <= 1'b1;
        end
    end
    // internal reset pulls the pin low; oe low means driving
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = (ipulse_reg == 5'h00);
    // core reset from pin, power-up or watchdog pulse
    assign cpu_rst_n = rpin_s && (ipulse_reg == 5'h00);
    // boot select caught at release of core reset
    logic boot_m, rec_reg, cpu_rst_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_m <= 1'b0;
            boot_s <= 1'b0;
            rec_reg <= 1'b0;
            cpu_rst_d <= 1'b0;
        end else begin
            boot_m <= boot_select;
            boot_s <= boot_m;
            cpu_rst_d <= cpu_rst_n;
            if (cpu_rst_n && !cpu_rst_d) begin
                rec_reg <= boot_s;
            end
        end
    end
    assign recovery_mode = rec_reg;
    ////////////////////////////////////////////////////////////////////////
    // rtc tick and settle counter
    logic [10:0] rdiv_reg, rdiv_next;
    logic [31:0] rstab_reg, rstab_next;
    always_comb begin
        rdiv_next = (rdiv_reg == 11'(`SWPC_RTC_DIV - 1)) ? 11'h000 :
                    rdiv_reg + 11'h001;
        rstab_next = (rstab_reg == RTC_STABLE_CYC) ? rstab_reg :
                     rstab_reg + 32'd1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdiv_reg <= 11'h000;
            rstab_reg <= 32'h0000_0000;
        end else begin
            rdiv_reg <= rdiv_next;
            rstab_reg <= rstab_next;
        end
    end
    // tick approximates 32.768 kHz from 40 MHz, free running
    assign rtc_tick = (rdiv_reg == 11'h000);
    assign rtc_stable = (rstab_reg == RTC_STABLE_CYC);
    ////////////////////////////////////////////////////////////////////////
    // power state machine
    swpc_state_e state_reg, state_next;
    logic [8:0] wcnt_reg, wcnt_next;
    logic gpio_event, wake_event, handler_busy;
    assign gpio_event = |(gpio_mux & ~gpio_prev_reg & irq_en_reg);
    // no software source here: only hardware events wake
    assign wake_event = wake_pin || gpio_event || radio_s || rtc_s;
    assign handler_busy = |irq_pend_reg;
    always_comb begin
        state_next = state_reg;
        wcnt_next = wcnt_reg;
        case (state_reg)
            SWPC_ACTIVE: begin
                // halt core when idle and allowed; wake pin forbids sleep
                if (ctrl_reg[1] && ctrl_reg[0] && !wake_pin && !handler_busy
                        && !wake_event) begin
                    state_next = SWPC_DEEP;
                end else if (ctrl_reg[0] && !wake_pin && !handler_busy) begin
                    state_next = SWPC_SHALLOW;
                end
            end
            SWPC_SHALLOW: begin
                // one-cycle resume, well under 1 us
                if (wake_pin || handler_busy || gpio_event || !ctrl_reg[0]
                        || ctrl_reg[1]) begin
                    state_next = SWPC_ACTIVE;
                end
            end
            SWPC_DEEP: begin
                if (wake_event) begin
                    state_next = SWPC_WAKING;
                    wcnt_next = 9'(`SWPC_DEEP_WAKE_CYC);
                end
            end
            SWPC_WAKING: begin
                if (wcnt_reg == 9'h000) begin
                    state_next = SWPC_ACTIVE;
                end else begin
                    wcnt_next = wcnt_reg - 9'h001;
                end
            end
            default: begin
                state_next = SWPC_ACTIVE;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SWPC_ACTIVE;
            wcnt_reg <= 9'h000;
        end else begin
            state_reg <= state_next;
            wcnt_reg <= wcnt_next;
        end
    end
    // core stops in both sleeps and while waking; clocks stop only in deep, uart in deep and waking
    assign core_halt = (state_reg != SWPC_ACTIVE);
    assign sys_clk_en = (state_reg != SWPC_DEEP);
    assign uart_en = (state_reg == SWPC_ACTIVE) ||
                     (state_reg == SWPC_SHALLOW);
    // flow control follows uart_en, up in active and shallow sleep; host waits on it
    assign uart_ready = uart_en;
    assign ram_retain = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // pending handler flags: set wins over clear
    logic [15:0] irq_clr;
    always_comb begin
        irq_pend_next = (irq_pend_reg & ~irq_clr) |
                        (gpio_mux & ~gpio_prev_reg & irq_en_reg);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_reg <= 16'h0000;
            gpio_prev_reg <= 16'h0000;
        end else begin
            irq_pend_reg <= irq_pend_next;
            gpio_prev_reg <= gpio_mux;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    logic wr, rd_ok;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign rd_ok = (paddr == `SWPC_ADDR_CTRL) || (paddr == `SWPC_ADDR_STAT) ||
                   (paddr == `SWPC_ADDR_WAKE) || (paddr == `SWPC_ADDR_INT);
    assign pslverr = psel && penable && !rd_ok;
    assign wdog_kick = wr && (paddr == `SWPC_ADDR_CTRL);
    // handler completion clears pending; write of ones also clears
    always_comb begin
        irq_clr = 16'h0000;
        if (handler_done) begin
            irq_clr = 16'hFFFF;
        end else if (wr && paddr == `SWPC_ADDR_STAT) begin
            irq_clr = pwdata[15:0];
        end
    end
    always_comb begin
        ctrl_next = ctrl_reg;
        wake_sel_next = wake_sel_reg;
        irq_en_next = irq_en_reg;
        port_sel_next = port_sel_reg;
        if (wr && paddr == `SWPC_ADDR_CTRL) begin
            ctrl_next = pwdata[2:0];
        end else if (wr && paddr == `SWPC_ADDR_WAKE) begin
            wake_sel_next = pwdata[3:0];
        end else if (wr && paddr == `SWPC_ADDR_INT) begin
            irq_en_next = pwdata[15:0];
            port_sel_next = pwdata[31:16];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= 3'h0;
            wake_sel_reg <= 4'h0;
            irq_en_reg <= 16'h0000;
            port_sel_reg <= 16'h0000;
            prdata <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            wake_sel_reg <= wake_sel_next;
            irq_en_reg <= irq_en_next;
            port_sel_reg <= port_sel_next;
            if (psel && !penable && !pwrite) begin
                if (paddr == `SWPC_ADDR_CTRL) begin
                    prdata <= {29'h0, ctrl_reg};
                end else if (paddr == `SWPC_ADDR_STAT) begin
                    prdata <= {8'h00, 1'b0, state_reg, rtc_stable,
                               rec_reg, wake_pin, 1'b0, irq_pend_reg};
                end else if (paddr == `SWPC_ADDR_WAKE) begin
                    prdata <= {28'h0, wake_sel_reg};
                end else if (paddr == `SWPC_ADDR_INT) begin
                    prdata <= {port_sel_reg, irq_en_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_wake_no_sleep;
        @(posedge clk) disable iff (!rst_n)
        wake_pin && state_reg == SWPC_ACTIVE |=> state_reg == SWPC_ACTIVE;
    endproperty
    a_wake_no_sleep: assert property (p_wake_no_sleep)
        else $error("slept with wake pin high");
    property p_deep_delay;
        @(posedge clk) disable iff (!rst_n)
        state_reg == SWPC_DEEP && wake_event |=> !uart_en [*8];
    endproperty
    a_deep_delay: assert property (p_deep_delay)
        else $error("uart up too soon after deep");
    property p_deep_wake_bound;
        @(posedge clk) disable iff (!rst_n)
        state_reg == SWPC_DEEP && wake_event |-> ##[1:277] uart_en;
    endproperty
    a_deep_wake_bound: assert property (p_deep_wake_bound)
        else $error("deep wake too slow");
    property p_shallow_fast;
        @(posedge clk) disable iff (!rst_n)
        state_reg == SWPC_SHALLOW && (wake_pin || gpio_event) |=> !core_halt;
    endproperty
    a_shallow_fast: assert property (p_shallow_fast)
        else $error("shallow resume slow");
    property p_deep_uart;
        @(posedge clk) disable iff (!rst_n)
        state_reg == SWPC_DEEP |-> !uart_en && !sys_clk_en;
    endproperty
    a_deep_uart: assert property (p_deep_uart)
        else $error("uart alive in deep");
    property p_deep_entry;
        @(posedge clk) disable iff (!rst_n)
        $rose(state_reg == SWPC_DEEP) |-> $past(ctrl_reg[0] && !handler_busy);
    endproperty
    a_deep_entry: assert property (p_deep_entry)
        else $error("bad deep entry");
    property p_int_pulse;
        @(posedge clk) disable iff (!rst_n)
        rst_n && int_rst |=> !reset_pin_oe && !cpu_rst_n;
    endproperty
    a_int_pulse: assert property (p_int_pulse)
        else $error("internal reset not driven");
    property p_ram;
        @(posedge clk) disable iff (!rst_n) ram_retain;
    endproperty
    a_ram: assert property (p_ram)
        else $error("ram lost");
endmodule : swpc_top
`default_nettype wire

// [verification/swpc_host_model.sv]
// host model: holds the wake pin, waits for flow control, sends bytes
// assumes uart_ready is a level on the same clock as the bench
`timescale 1ns/100ps
`default_nettype none
module swpc_host_model (
    // clock
    input wire logic clk,
    // bench control
    input wire logic start,
    input wire logic [7:0] nbytes,
    input wire logic [7:0] lead,
    output logic busy,
    output logic byte_valid,
    output int wait_cyc,
    // device side
    output logic wake,
    input wire logic uart_ready
);
    ////////////////////////////////////////////////////////////////////
    // one transfer per start; wake stays up through the last byte, dropping with byte_valid, so the
    // device cannot drop into deep sleep with a byte in flight
    initial begin
        wake = 1'b0;
        busy = 1'b0;
        byte_valid = 1'b0;
        wait_cyc = 0;
        forever begin
            @(posedge clk);
            if (start === 1'b1) begin
                busy <= 1'b1;
                wake <= 1'b1;
                wait_cyc = 0;
                do begin
                    @(negedge clk);
                    wait_cyc++;
                end while (uart_ready !== 1'b1 && wait_cyc < 2000);
                @(posedge clk);
                // lead lets the host answer slowly while holding wake
                repeat (lead) @(posedge clk);
                repeat (nbytes) begin
                    byte_valid <= 1'b1;
                    @(posedge clk);
                end
                byte_valid <= 1'b0;
                wake <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule : swpc_host_model
`default_nettype wire

// [verification/sleep_wake_power_control_bench.sv]
// bench of the sleep, wake and reset controller
// assumes the design files and the host model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "swpc_consts.svh"
module sleep_wake_power_control_bench;
    import swpc_pkg::*;
    localparam int WIDX = 3; // port-a pin used as wake
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] gpa = 16'h0000;
    logic [15:0] gpb = 16'h0000;
    logic radio = 1'b0;
    logic alarm = 1'b0;
    logic hdone = 1'b0;
    logic ext_rst = 1'b0; // external open-drain driver pulling low
    logic boot = 1'b1;
    logic hstart = 1'b0;
    logic [7:0] hlead = 8'h14;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pin_out, pin_oe, halt, clk_en, uen, urdy;
    logic retain, recov, stable, tick, cpu_rst_n, hbusy, hbyte, hwake;
    int hwait, n, k, hi, mx, run, bad;
    int num_errors = 0, tests_run = 0, cyc = 0, oe_len = 0, oe_run = 0;
    int tick_cnt = 0, tick_per = 0, stab_cnt = 0;
    wire logic [15:0] gpio_a = gpa | ({15'h0000, hwake} << WIDX);
    // pin pulled up unless the device or the external driver pulls it
    wire logic pin_lvl = (pin_oe ? 1'b1 : pin_out) & ~ext_rst;

    always #12.5 clk = ~clk;

    swpc_top #(.RTC_STABLE_CYC(100), .WDOG_CYC(1000)) DUT (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_port_a(gpio_a),
        .gpio_port_b(gpb), .radio_active(radio), .rtc_alarm(alarm),
        .handler_done(hdone), .reset_pin_in(pin_lvl),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .boot_select(boot), .core_halt(halt), .sys_clk_en(clk_en),
        .uart_en(uen), .uart_ready(urdy), .ram_retain(retain),
        .recovery_mode(recov), .rtc_stable(stable), .rtc_tick(tick),
        .cpu_rst_n(cpu_rst_n));

    swpc_host_model host (.clk(clk), .start(hstart), .nbytes(8'h04),
        .lead(hlead), .busy(hbusy), .byte_valid(hbyte),
        .wait_cyc(hwait), .wake(hwake), .uart_ready(urdy));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // one apb transfer; an idle edge first keeps psel from being
    // assigned twice in one time step between transfers
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) begin
            num_errors++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic sig(input int s);
        case (s)
            0: return uen;
            1: return urdy;
            2: return hbusy;
            4: return halt;
            default: return pin_oe;
        endcase
    endfunction : sig

    // bounded wait; n reaching lim means the event never came
    task automatic wait_sig(input int s, input logic v, input int lim);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_sig

    ////////////////////////////////////////////////////////////////////
    // monitors: reset pulse length, tick period, settle time, bytes
    always @(negedge clk) begin
        oe_run = pin_oe ? 0 : oe_run + 1;
        if (oe_run != 0) oe_len = oe_run;
        if (tick) begin
            tick_per = tick_cnt + 1;
            tick_cnt = 0;
        end else begin
            tick_cnt++;
        end
        if (rst_n && !stable) stab_cnt++;
        if (hbyte) chk(urdy, 1'b1);
    end

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (120) @(posedge clk);
        boot <= 1'b0;
        chk(oe_len, 16);
        chk(recov, 1'b1);
        chk(retain, 1'b1);
        chk(stab_cnt inside {[98:102]}, 1'b1);
        apb(0, `SWPC_ADDR_CTRL, 0);
        chk(rd, `SWPC_CTRL_RESET);
        apb(0, `SWPC_ADDR_STAT, 0);
        chk(rd[22:18], {SWPC_ACTIVE, 2'b11});
        apb(0, 12'h010, 0);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        // channel 5 belongs to port b; port a pin 5 must not set it
        apb(1, `SWPC_ADDR_INT, 32'h0020_0020);
        gpa <= 16'h0020;
        repeat (6) @(posedge clk);
        apb(0, `SWPC_ADDR_STAT, 0);
        chk(rd[5], 1'b0);
        gpb <= 16'h0020;
        repeat (6) @(posedge clk);
        apb(0, `SWPC_ADDR_STAT, 0);
        chk(rd[5], 1'b1);
        apb(1, `SWPC_ADDR_STAT, 32'h0000_0020);
        apb(0, `SWPC_ADDR_STAT, 0);
        chk(rd[5], 1'b0);
        gpa <= 16'h0000;
        gpb <= 16'h0000;
        // shallow sleep: core stays halted, clocks and uart stay on
        apb(1, `SWPC_ADDR_CTRL, 32'h1);
        bad = 0;
        hi = 0;
        mx = 0;
        run = 0;
        repeat (80) begin
            @(negedge clk);
            if (clk_en !== 1'b1 || uen !== 1'b1) bad++;
            run = (halt === 1'b1) ? run + 1 : 0;
            if (run > 0) hi++;
            if (run > mx) mx = run;
        end
        chk(bad, 0);
        // a gpio irq must bring the core back well inside 1 us
        @(posedge clk);
        gpb[5] <= 1'b1;
        wait_sig(4, 1'b0, 60);
        chk(hi > 70 && mx > 70 && n < 40, 1'b1);
        @(posedge clk);
        gpb[5] <= 1'b0;
        hdone <= 1'b1;
        @(posedge clk);
        hdone <= 1'b0;
        // deep sleep, then the host wakes it through the wake pin
        apb(1, `SWPC_ADDR_WAKE, WIDX);
        apb(1, `SWPC_ADDR_CTRL, 32'h7);
        wait_sig(0, 1'b0, 40);
        chk({clk_en, urdy, n < 40}, 3'b001);
        @(posedge clk);
        hstart <= 1'b1;
        @(posedge clk);
        hstart <= 1'b0;
        repeat (2) @(posedge clk);
        wait_sig(2, 1'b0, 1000);
        chk(hwait <= 280, 1'b1);
        wait_sig(0, 1'b0, 40);
        chk(n < 40, 1'b1);
        // a ctrl write and port a pin 4, which has no irq enabled, must not wake it
        apb(1, `SWPC_ADDR_CTRL, 32'h7);
        gpa <= 16'h0010;
        repeat (30) @(posedge clk);
        chk(uen, 1'b0);
        gpa <= 16'h0000;
        // other wake sources: gpio irq, radio, rtc alarm
        for (k = 0; k < 3; k++) begin
            apb(1, `SWPC_ADDR_CTRL, 32'h7);
            wait_sig(0, 1'b0, 40);
            @(posedge clk);
            gpb[5] <= (k == 0);
            radio <= (k == 1);
            alarm <= (k == 2);
            wait_sig(1, 1'b1, 400);
            chk(n <= 280, 1'b1);
            @(posedge clk);
            gpb <= 16'h0000;
            radio <= 1'b0;
            alarm <= 1'b0;
            repeat (8) @(posedge clk);
            if (k == 0) chk(uen, 1'b1);
            hdone <= 1'b1;
            @(posedge clk);
            hdone <= 1'b0;
            wait_sig(0, 1'b0, 40);
            chk(n < 40, 1'b1);
        end
        chk(tick_per, `SWPC_RTC_DIV);
        // pin reset, strap low this time
        @(posedge clk);
        ext_rst <= 1'b1;
        repeat (6) @(posedge clk);
        chk(cpu_rst_n, 1'b0);
        ext_rst <= 1'b0;
        repeat (60) @(posedge clk);
        chk({cpu_rst_n, recov}, 2'b10);
        // watchdog expiry without further kicks
        apb(1, `SWPC_ADDR_CTRL, 0);
        wait_sig(3, 1'b0, 1100);
        chk(n > 950 && n < 1050, 1'b1);
        repeat (40) @(posedge clk);
        chk({oe_len, retain}, {32'd16, 1'b1});
        conclude();
    end
endmodule : sleep_wake_power_control_bench
`default_nettype wire
